// ==== hw/pcs_pkg.sv ====
// Constants for the per-port PHY control and status register bank
package pcs_pkg;

    // ----------------------------------------------------------------
    // Register offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] REG_P1_STATUS0 = 8'h29;
    localparam logic [7:0] REG_P1_SPECIAL = 8'h2a;
    localparam logic [7:0] REG_P1_CONTROL5 = 8'h2c;
    localparam logic [7:0] REG_P2_STATUS0 = 8'h39;
    localparam logic [7:0] REG_P2_SPECIAL = 8'h3a;
    localparam logic [7:0] REG_P2_CONTROL5 = 8'h3c;
    localparam logic [7:0] REG_REFCLK_CTRL = 8'h57;
    localparam logic [7:0] PORT_STRIDE = REG_P2_STATUS0 - REG_P1_STATUS0;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int BIT_REFCLK_DIS = 3;
    localparam int BIT_XOVER_SEL = 7;
    localparam int BIT_POL_REV = 5;
    localparam int BIT_TX_FLOW = 4;
    localparam int BIT_RX_FLOW = 3;
    localparam int BIT_SPEED = 2;
    localparam int BIT_DUPLEX = 1;
    localparam int BIT_FORCE_LINK = 3;
    localparam int BIT_PWR_SAVE = 2;
    localparam int BIT_REM_LOOP = 1;
    localparam int BIT_AN_DIS = 7;
    localparam int BIT_FRC_SPEED = 6;
    localparam int BIT_FRC_DUPLEX = 5;
    localparam int ADV_MSB = 4;

    // ----------------------------------------------------------------
    // Writable masks and reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] MASK_REFCLK = 8'h08;
    localparam logic [7:0] MASK_STATUS0 = 8'h80;
    localparam logic [7:0] MASK_SPECIAL = 8'h0e;
    localparam logic [7:0] MASK_CONTROL5 = 8'hff;
    localparam logic [7:0] RST_REFCLK = 8'h00;
    localparam logic [7:0] RST_STATUS0 = 8'h80;
    localparam logic [7:0] RST_SPECIAL = 8'h00;
    localparam logic [7:0] RST_CONTROL5 = 8'h5f;
    localparam logic [7:0] READ_IDLE = 8'h00;

endpackage

// ==== hw/pcs_port_regs.sv ====
// Control and status registers of one copper port
`timescale 1ns/100ps
module pcs_port_regs
    import pcs_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Register writes
    input wire logic wrStatus0,
    input wire logic wrSpecial,
    input wire logic wrControl5,
    input wire logic [7:0] wrData,
    // PHY state
    input wire logic rxPolarityReversed,
    input wire logic txFlowActive,
    input wire logic rxFlowActive,
    input wire logic anFailed,
    input wire logic anSpeed100,
    input wire logic anFullDuplex,
    // Register contents
    output logic [7:0] status0Rd,
    output logic [7:0] specialRd,
    output logic [7:0] control5Rd,
    // PHY controls
    output logic linkSpeed100,
    output logic linkFullDuplex
);

    // ----------------------------------------------------------------
    // Writable storage
    // ----------------------------------------------------------------
    logic [7:0] status0Ctl_ff;
    logic [7:0] special_ff;
    logic [7:0] control5_ff;
    logic [7:0] status0Live_ff;
    logic nxt_speed100;
    logic nxt_fullDuplex;

    // Crossover selector, only bit 7 takes writes
    always_ff @(posedge clk) begin
        if (rst) begin
            status0Ctl_ff <= RST_STATUS0;
        end else if (wrStatus0) begin
            status0Ctl_ff <= wrData & MASK_STATUS0;
        end
    end

    // Force link, power save and remote loopback
    always_ff @(posedge clk) begin
        if (rst) begin
            special_ff <= RST_SPECIAL;
        end else if (wrSpecial) begin
            special_ff <= wrData & MASK_SPECIAL;
        end
    end

    // Negotiation control and advertised abilities
    always_ff @(posedge clk) begin
        if (rst) begin
            control5_ff <= RST_CONTROL5;
        end else if (wrControl5) begin
            control5_ff <= wrData & MASK_CONTROL5;
        end
    end

    // ----------------------------------------------------------------
    // Speed and duplex resolution
    // ----------------------------------------------------------------
    always_comb begin
        nxt_speed100 = anSpeed100;
        if (control5_ff[BIT_AN_DIS]) begin
            nxt_speed100 = control5_ff[BIT_FRC_SPEED];
        end
        nxt_fullDuplex = anFullDuplex;
        if (control5_ff[BIT_AN_DIS] || anFailed) begin
            nxt_fullDuplex = control5_ff[BIT_FRC_DUPLEX];
        end
    end

    // Live status bits captured every cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            status0Live_ff <= 8'h00;
        end else begin
            status0Live_ff <= 8'h00;
            status0Live_ff[BIT_POL_REV] <= rxPolarityReversed;
            status0Live_ff[BIT_TX_FLOW] <= txFlowActive;
            status0Live_ff[BIT_RX_FLOW] <= rxFlowActive;
            status0Live_ff[BIT_SPEED] <= nxt_speed100;
            status0Live_ff[BIT_DUPLEX] <= nxt_fullDuplex;
        end
    end

    // Readback and resolved link mode
    assign status0Rd = status0Ctl_ff | status0Live_ff;
    assign specialRd = special_ff;
    assign control5Rd = control5_ff;
    assign linkSpeed100 = status0Live_ff[BIT_SPEED];
    assign linkFullDuplex = status0Live_ff[BIT_DUPLEX];

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    chk_forced_speed: assert property (@(posedge clk) disable iff (rst)
        control5_ff[BIT_AN_DIS] && !$past(rst) ##1 $stable(control5_ff) |->
        linkSpeed100 == control5_ff[BIT_FRC_SPEED])
        else $error("forced speed not applied");
    chk_failed_duplex: assert property (@(posedge clk) disable iff (rst)
        anFailed && !wrControl5 |=> linkFullDuplex == control5_ff[BIT_FRC_DUPLEX])
        else $error("forced duplex not applied on failed negotiation");
    chk_polarity_bit: assert property (@(posedge clk) disable iff (rst)
        rxPolarityReversed |=> status0Rd[BIT_POL_REV])
        else $error("polarity status not reported");
    chk_flow_bits: assert property (@(posedge clk) disable iff (rst)
        ##1 status0Rd[BIT_TX_FLOW] == $past(txFlowActive) &&
        status0Rd[BIT_RX_FLOW] == $past(rxFlowActive))
        else $error("flow status mismatch");
    chk_status_ro: assert property (@(posedge clk) disable iff (rst)
        wrStatus0 |=> status0Ctl_ff[6:0] == 7'h00)
        else $error("read-only status bit took a write");

endmodule

// ==== hw/pcs_regs_top.sv ====
// Port PHY control and status register bank with reference clock gate
`timescale 1ns/100ps
// Function
// - Bit 3 set stops port 4 reference clock
// - Status-0 bit 7 picks crossover algorithm
// - Status-0 bit 5 shows reversed receive polarity
// - Status-0 bit 4 shows transmit flow control
// - Status-0 bit 3 shows receive flow control
// - Status-0 bit 2 shows resolved speed
// - Status-0 bit 1 shows resolved duplex
// - Special bit 3 forces link pass
// - Special bit 2 enables power saving
// - Special bit 1 enables remote loopback
// - Control-5 bit 7 disables auto-negotiation
// - Control-5 bit 6 forces speed, default 100
// - Control-5 bit 5 forces duplex, default half
// - Control-5 bit 4 advertises flow control
// - Control-5 bit 3 advertises 100 full duplex
// - Control-5 bit 2 advertises 100 half duplex
// - Control-5 bit 1 advertises 10 full duplex
// - Control-5 bit 0 advertises 10 half duplex
// - Status-0 at 0x29 and 0x39, rest reserved
module pcs_regs_top
    import pcs_pkg::*;
#(
    parameter int NUM_PORTS = 2
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Management register access
    input wire logic [7:0] regAddr,
    input wire logic regWrEn,
    input wire logic [7:0] regWrData,
    input wire logic regRdEn,
    output logic [7:0] regRdData,
    output logic regRdValid,
    // PHY state per port
    input wire logic [NUM_PORTS-1:0] rxPolarityReversed,
    input wire logic [NUM_PORTS-1:0] txFlowActive,
    input wire logic [NUM_PORTS-1:0] rxFlowActive,
    input wire logic [NUM_PORTS-1:0] anFailed,
    input wire logic [NUM_PORTS-1:0] anSpeed100,
    input wire logic [NUM_PORTS-1:0] anFullDuplex,
    // PHY controls per port
    output logic [NUM_PORTS-1:0] crossoverAlgorithmSelect,
    output logic [NUM_PORTS-1:0] forceLinkPass,
    output logic [NUM_PORTS-1:0] powerSaveEn,
    output logic [NUM_PORTS-1:0] remoteLoopbackEn,
    output logic [NUM_PORTS-1:0] anDisable,
    output logic [NUM_PORTS-1:0] linkSpeed100,
    output logic [NUM_PORTS-1:0] linkFullDuplex,
    output logic [NUM_PORTS*5-1:0] advertiseCaps,
    // Fourth MAC reduced-MII reference clock pin
    output logic referenceClockPinEn
);

    // ----------------------------------------------------------------
    // Address decode helpers
    // ----------------------------------------------------------------

    // Offset of a port register, first port as the base
    function automatic logic [7:0] portAddr(input int port, input logic [7:0] firstOfs);
        portAddr = firstOfs + 8'(port * PORT_STRIDE);
    endfunction

    // True when a write or read strobe hits a given offset
    function automatic logic hitWrite(input logic [7:0] addr, input logic [7:0] ofs,
                                      input logic en);
        hitWrite = en && (addr == ofs);
    endfunction

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    logic [7:0] refClkCtl_ff;
    logic [7:0] regRdData_ff;
    logic regRdValid_ff;
    logic refClkPinEn_ff;
    logic [7:0] nxt_rdData;
    logic [7:0] status0Rd [NUM_PORTS];
    logic [7:0] specialRd [NUM_PORTS];
    logic [7:0] control5Rd [NUM_PORTS];
    logic [NUM_PORTS-1:0] wrStatus0;
    logic [NUM_PORTS-1:0] wrSpecial;
    logic [NUM_PORTS-1:0] wrControl5;
    logic [NUM_PORTS-1:0] hitStatus0;

    // ----------------------------------------------------------------
    // Per-port register sets
    // ----------------------------------------------------------------
    for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
        // Write strobes and status read hit for this port
        assign wrStatus0[p] = hitWrite(regAddr, portAddr(p, REG_P1_STATUS0), regWrEn);
        assign wrSpecial[p] = hitWrite(regAddr, portAddr(p, REG_P1_SPECIAL), regWrEn);
        assign wrControl5[p] = hitWrite(regAddr, portAddr(p, REG_P1_CONTROL5), regWrEn);
        assign hitStatus0[p] = hitWrite(regAddr, portAddr(p, REG_P1_STATUS0), regRdEn);

        pcs_port_regs u_port (
            .clk(clk),
            .rst(rst),
            .wrStatus0(wrStatus0[p]),
            .wrSpecial(wrSpecial[p]),
            .wrControl5(wrControl5[p]),
            .wrData(regWrData),
            .rxPolarityReversed(rxPolarityReversed[p]),
            .txFlowActive(txFlowActive[p]),
            .rxFlowActive(rxFlowActive[p]),
            .anFailed(anFailed[p]),
            .anSpeed100(anSpeed100[p]),
            .anFullDuplex(anFullDuplex[p]),
            .status0Rd(status0Rd[p]),
            .specialRd(specialRd[p]),
            .control5Rd(control5Rd[p]),
            .linkSpeed100(linkSpeed100[p]),
            .linkFullDuplex(linkFullDuplex[p])
        );

        // Controls straight from the stored bits
        assign crossoverAlgorithmSelect[p] = status0Rd[p][BIT_XOVER_SEL];
        assign forceLinkPass[p] = specialRd[p][BIT_FORCE_LINK];
        assign powerSaveEn[p] = specialRd[p][BIT_PWR_SAVE];
        assign remoteLoopbackEn[p] = specialRd[p][BIT_REM_LOOP];
        assign anDisable[p] = control5Rd[p][BIT_AN_DIS];
        assign advertiseCaps[p*5 +: 5] =
            control5Rd[p][ADV_MSB:0];

        // Status slot of this port returns its live status byte
        chk_status_slot: assert property (@(posedge clk) disable iff (rst)
            hitStatus0[p] |=> regRdValid && regRdData == $past(status0Rd[p]))
            else $error("status slot read returns wrong byte");
    end

    // ----------------------------------------------------------------
    // Reference clock control
    // ----------------------------------------------------------------

    // Only the disable bit takes writes
    always_ff @(posedge clk) begin
        if (rst) begin
            refClkCtl_ff <= RST_REFCLK;
        end else if (hitWrite(regAddr, REG_REFCLK_CTRL, regWrEn)) begin
            refClkCtl_ff <= regWrData & MASK_REFCLK;
        end
    end

    // Pin driver enable, low while disabled
    always_ff @(posedge clk) begin
        if (rst) begin
            refClkPinEn_ff <= 1'b1;
        end else begin
            refClkPinEn_ff <= !refClkCtl_ff[BIT_REFCLK_DIS];
        end
    end

    assign referenceClockPinEn = refClkPinEn_ff;

    // ----------------------------------------------------------------
    // Read path
    // ----------------------------------------------------------------

    // Read mux, unmapped and reserved slots return zero
    always_comb begin
        nxt_rdData = READ_IDLE;
        if (regAddr == REG_REFCLK_CTRL) begin
            nxt_rdData = refClkCtl_ff;
        end
        for (int p = 0; p < NUM_PORTS; p++) begin
            if (regAddr == portAddr(p, REG_P1_STATUS0)) begin
                nxt_rdData = status0Rd[p];
            end
            if (regAddr == portAddr(p, REG_P1_SPECIAL)) begin
                nxt_rdData = specialRd[p];
            end
            if (regAddr == portAddr(p, REG_P1_CONTROL5)) begin
                nxt_rdData = control5Rd[p];
            end
        end
    end

    // Read data held until the next read
    always_ff @(posedge clk) begin
        if (rst) begin
            regRdData_ff <= READ_IDLE;
        end else if (regRdEn) begin
            regRdData_ff <= nxt_rdData;
        end
    end

    // One-cycle read strobe
    always_ff @(posedge clk) begin
        if (rst) begin
            regRdValid_ff <= 1'b0;
        end else begin
            regRdValid_ff <= regRdEn;
        end
    end

    assign regRdData = regRdData_ff;
    assign regRdValid = regRdValid_ff;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------

    // Clock pin follows the disable bit two edges after the write
    chk_refclk_gate: assert property (@(posedge clk) disable iff (rst)
        regWrEn && regAddr == REG_REFCLK_CTRL && regWrData[BIT_REFCLK_DIS]
        |-> ##2 !referenceClockPinEn)
        else $error("reference clock still driven after disable");

    chk_refclk_enable: assert property (@(posedge clk) disable iff (rst)
        regWrEn && regAddr == REG_REFCLK_CTRL && !regWrData[BIT_REFCLK_DIS]
        |-> ##2 referenceClockPinEn)
        else $error("reference clock not driven after enable");

    // Clock pin keeps its state while the control register is left alone
    chk_refclk_hold: assert property (@(posedge clk) disable iff (rst)
        !(regWrEn && regAddr == REG_REFCLK_CTRL) |-> ##2 $stable(referenceClockPinEn))
        else $error("reference clock pin changed without a write");

    chk_unmapped_zero: assert property (@(posedge clk) disable iff (rst)
        regRdEn && regAddr != REG_REFCLK_CTRL && regAddr != REG_P1_STATUS0 &&
        regAddr != REG_P1_SPECIAL && regAddr != REG_P1_CONTROL5 &&
        regAddr != REG_P2_STATUS0 && regAddr != REG_P2_SPECIAL &&
        regAddr != REG_P2_CONTROL5 |=> regRdValid && regRdData == READ_IDLE)
        else $error("unmapped read not zero");

    // Read answered exactly one edge after the strobe
    chk_read_strobe: assert property (@(posedge clk) disable iff (rst)
        !$past(rst) |-> regRdValid == $past(regRdEn))
        else $error("read valid not one edge after the strobe");

    // Read data stands until the next read
    chk_read_hold: assert property (@(posedge clk) disable iff (rst)
        !regRdEn |=> $stable(regRdData))
        else $error("read data changed without a read");

    chk_refclk_reserved: assert property (@(posedge clk) disable iff (rst)
        regWrEn && regAddr == REG_REFCLK_CTRL ##1 regRdEn && regAddr == REG_REFCLK_CTRL
        |=> regRdData == ($past(regWrData, 2) & MASK_REFCLK))
        else $error("reference clock register readback wrong");

    chk_xover_write: assert property (@(posedge clk) disable iff (rst)
        regWrEn && regAddr == REG_P1_STATUS0 |=>
        crossoverAlgorithmSelect[0] == $past(regWrData[BIT_XOVER_SEL]))
        else $error("crossover select not stored");

    // Second port crossover selector
    chk_xover_write_p2: assert property (@(posedge clk) disable iff (rst)
        regWrEn && regAddr == REG_P2_STATUS0 |=>
        crossoverAlgorithmSelect[1] == $past(regWrData[BIT_XOVER_SEL]))
        else $error("second port crossover select not stored");

    chk_special_write: assert property (@(posedge clk) disable iff (rst)
        regWrEn && regAddr == REG_P2_SPECIAL |=>
        powerSaveEn[1] == $past(regWrData[BIT_PWR_SAVE]) &&
        forceLinkPass[1] == $past(regWrData[BIT_FORCE_LINK]) &&
        remoteLoopbackEn[1] == $past(regWrData[BIT_REM_LOOP]))
        else $error("special control bits not stored");

    // First port force link, power save and loopback
    chk_special_write_p1: assert property (@(posedge clk) disable iff (rst)
        regWrEn && regAddr == REG_P1_SPECIAL |=>
        forceLinkPass[0] == $past(regWrData[BIT_FORCE_LINK]) &&
        powerSaveEn[0] == $past(regWrData[BIT_PWR_SAVE]) &&
        remoteLoopbackEn[0] == $past(regWrData[BIT_REM_LOOP]))
        else $error("first port special control bits not stored");

    chk_adv_write: assert property (@(posedge clk) disable iff (rst)
        regWrEn && regAddr == REG_P1_CONTROL5 |=>
        advertiseCaps[ADV_MSB:0] == $past(regWrData[ADV_MSB:0]) &&
        anDisable[0] == $past(regWrData[BIT_AN_DIS]))
        else $error("advertised abilities not stored");

    // Second port advertised abilities and negotiation disable
    chk_adv_write_p2: assert property (@(posedge clk) disable iff (rst)
        regWrEn && regAddr == REG_P2_CONTROL5 |=>
        advertiseCaps[5 +: 5] == $past(regWrData[ADV_MSB:0]) &&
        anDisable[1] == $past(regWrData[BIT_AN_DIS]))
        else $error("second port abilities not stored");

    chk_reset_values: assert property (@(posedge clk)
        rst |=> advertiseCaps == {NUM_PORTS{5'h1f}} && anDisable == '0 &&
        crossoverAlgorithmSelect == '1 && powerSaveEn == '0 && referenceClockPinEn)
        else $error("reset values wrong");

    chk_speed_report: assert property (@(posedge clk) disable iff (rst)
        regRdEn && regAddr == REG_P2_STATUS0 |=>
        regRdData[BIT_SPEED] == $past(linkSpeed100[1]) &&
        regRdData[BIT_DUPLEX] == $past(linkFullDuplex[1]))
        else $error("status speed or duplex mismatch");

    chk_rx_flow_rd: assert property (@(posedge clk) disable iff (rst)
        rxFlowActive[0] ##1 regRdEn && regAddr == REG_P1_STATUS0 |=>
        regRdData[BIT_RX_FLOW])
        else $error("receive flow status not read");

    chk_dup_report: assert property (@(posedge clk) disable iff (rst)
        anDisable[0] && !anFailed[0] ##1 $stable(anDisable[0]) |->
        linkFullDuplex[0] == $past(control5Rd[0][BIT_FRC_DUPLEX]))
        else $error("forced duplex not reported");

endmodule

// ==== tb/pcs_regs_top_test.sv ====
// Self-checking testbench of the port PHY control and status register bank
`timescale 1ns/100ps
module pcs_regs_top_test;
    import pcs_pkg::*;

`define CHK(nm, exp, got) begin compares++; if ((got) !== (exp)) begin errorCnt++; \
    $display("[FAIL] %s expected %h seen %h", nm, exp, got); end end

    // ----------------------------------------------------------------
    // Stimulus signals and design
    // ----------------------------------------------------------------
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] regAddr = 8'h00;
    logic regWrEn = 1'b0;
    logic [7:0] regWrData = 8'h00;
    logic regRdEn = 1'b0;
    logic [7:0] regRdData;
    logic regRdValid;
    logic [1:0] rxPolarityReversed = 2'h0;
    logic [1:0] txFlowActive = 2'h0;
    logic [1:0] rxFlowActive = 2'h0;
    logic [1:0] anFailed = 2'h0;
    logic [1:0] anSpeed100 = 2'h0;
    logic [1:0] anFullDuplex = 2'h0;
    logic [1:0] crossoverAlgorithmSelect, forceLinkPass, powerSaveEn, remoteLoopbackEn;
    logic [1:0] anDisable, linkSpeed100, linkFullDuplex;
    logic [9:0] advertiseCaps;
    logic referenceClockPinEn;
    int errorCnt = 0;
    int compares = 0;
    int seed = 32'hcaef43f5;
    // Mapped offsets first, then reserved and foreign slots that must read zero
    logic [7:0] addrTab [12] = '{8'h29, 8'h2a, 8'h2c, 8'h39, 8'h3a, 8'h3c, 8'h57,
                                 8'h19, 8'h49, 8'h2b, 8'h5a, 8'h2d};

    pcs_regs_top #(.NUM_PORTS(2)) uut (
        .clk(clk), .rst(rst), .regAddr(regAddr), .regWrEn(regWrEn),
        .regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData),
        .regRdValid(regRdValid), .rxPolarityReversed(rxPolarityReversed),
        .txFlowActive(txFlowActive), .rxFlowActive(rxFlowActive), .anFailed(anFailed),
        .anSpeed100(anSpeed100), .anFullDuplex(anFullDuplex),
        .crossoverAlgorithmSelect(crossoverAlgorithmSelect), .forceLinkPass(forceLinkPass),
        .powerSaveEn(powerSaveEn), .remoteLoopbackEn(remoteLoopbackEn),
        .anDisable(anDisable), .linkSpeed100(linkSpeed100), .linkFullDuplex(linkFullDuplex),
        .advertiseCaps(advertiseCaps), .referenceClockPinEn(referenceClockPinEn)
    );

    // 40 MHz clock
    initial begin
        forever #12.5 clk = ~clk;
    end

    // ----------------------------------------------------------------
    // Reference model
    // ----------------------------------------------------------------
    logic [1:0] mXover;
    logic [2:0] mSpec [2];
    logic [7:0] mCtl [2];
    logic mRefDis;

    task automatic resetModel();
        mXover = 2'b11;
        mSpec[0] = 3'h0;
        mSpec[1] = 3'h0;
        mCtl[0] = 8'h5f;
        mCtl[1] = 8'h5f;
        mRefDis = 1'b0;
    endtask

    // Status byte from held PHY state and forced settings
    function automatic logic [7:0] expStatus(int p);
        logic s, d;
        s = mCtl[p][7] ? mCtl[p][6] : anSpeed100[p];
        d = (mCtl[p][7] | anFailed[p]) ? mCtl[p][5] : anFullDuplex[p];
        return {mXover[p], 1'b0, rxPolarityReversed[p], txFlowActive[p], rxFlowActive[p],
                s, d, 1'b0};
    endfunction

    function automatic int portOf(logic [7:0] a);
        return (a >= REG_P2_STATUS0 && a < REG_REFCLK_CTRL) ? 1 : 0;
    endfunction

    function automatic logic [7:0] expRead(logic [7:0] a);
        case (a)
            REG_P1_STATUS0, REG_P2_STATUS0: return expStatus(portOf(a));
            REG_P1_SPECIAL, REG_P2_SPECIAL: return {4'h0, mSpec[portOf(a)], 1'b0};
            REG_P1_CONTROL5, REG_P2_CONTROL5: return mCtl[portOf(a)];
            REG_REFCLK_CTRL: return {4'h0, mRefDis, 3'h0};
            default: return 8'h00;
        endcase
    endfunction

    task automatic modelWrite(logic [7:0] a, logic [7:0] d);
        case (a)
            REG_P1_STATUS0, REG_P2_STATUS0: mXover[portOf(a)] = d[7];
            REG_P1_SPECIAL, REG_P2_SPECIAL: mSpec[portOf(a)] = d[3:1];
            REG_P1_CONTROL5, REG_P2_CONTROL5: mCtl[portOf(a)] = d;
            REG_REFCLK_CTRL: mRefDis = d[3];
            default: ;
        endcase
    endtask

    // ----------------------------------------------------------------
    // Bus tasks and checks
    // ----------------------------------------------------------------
    task automatic wrReg(logic [7:0] a, logic [7:0] d);
        @(posedge clk);
        regAddr <= a;
        regWrData <= d;
        regWrEn <= 1'b1;
        @(posedge clk);
        regWrEn <= 1'b0;
        modelWrite(a, d);
    endtask

    task automatic rdReg(input logic [7:0] a, output logic [7:0] v);
        @(posedge clk);
        regAddr <= a;
        regRdEn <= 1'b1;
        @(posedge clk);
        regRdEn <= 1'b0;
        #1;
        `CHK("read valid", 1'b1, regRdValid)
        v = regRdData;
        @(posedge clk);
        #1;
        `CHK("read valid end", 1'b0, regRdValid)
    endtask

    // Random PHY state, then let it settle into status and link outputs
    task automatic randPhy();
        @(posedge clk);
        rxPolarityReversed <= 2'($random(seed));
        txFlowActive <= 2'($random(seed));
        rxFlowActive <= 2'($random(seed));
        anFailed <= 2'($random(seed));
        anSpeed100 <= 2'($random(seed));
        anFullDuplex <= 2'($random(seed));
        repeat (2) @(posedge clk);
    endtask

    task automatic checkAll();
        logic [7:0] v, e, s0, s1;
        logic [9:0] adv;
        for (int i = 0; i < 12; i++) begin
            rdReg(addrTab[i], v);
            e = expRead(addrTab[i]);
            `CHK("register read", e, v)
        end
        s0 = expStatus(0);
        s1 = expStatus(1);
        adv = {mCtl[1][4:0], mCtl[0][4:0]};
        `CHK("crossover", mXover, crossoverAlgorithmSelect)
        `CHK("force link", {mSpec[1][2], mSpec[0][2]}, forceLinkPass)
        `CHK("power save", {mSpec[1][1], mSpec[0][1]}, powerSaveEn)
        `CHK("remote loop", {mSpec[1][0], mSpec[0][0]}, remoteLoopbackEn)
        `CHK("an disable", {mCtl[1][7], mCtl[0][7]}, anDisable)
        `CHK("link speed", {s1[2], s0[2]}, linkSpeed100)
        `CHK("link duplex", {s1[1], s0[1]}, linkFullDuplex)
        `CHK("advertise", adv, advertiseCaps)
        `CHK("ref clock", ~mRefDis, referenceClockPinEn)
    endtask

    task automatic finish_test();
        $display("Comparisons %0d, mismatches %0d", compares, errorCnt);
        if (errorCnt == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Watchdog against a hung handshake
    initial begin
        repeat (30000) @(posedge clk);
        errorCnt++;
        finish_test();
    end

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        resetModel();
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        checkAll();
        // Every forced and negotiated speed/duplex combination on both ports
        for (int i = 0; i < 64; i++) begin
            wrReg(REG_P1_CONTROL5, {i[5:3], 5'($random(seed))});
            wrReg(REG_P2_CONTROL5, {~i[5:3], 5'($random(seed))});
            @(posedge clk);
            anFailed <= {~i[2], i[2]};
            anSpeed100 <= {~i[1], i[1]};
            anFullDuplex <= {~i[0], i[0]};
            repeat (2) @(posedge clk);
            checkAll();
        end
        // Random writes across mapped, reserved and foreign offsets
        for (int i = 0; i < 40; i++) begin
            wrReg(addrTab[{$random(seed)} % 12], 8'($random(seed)));
            randPhy();
            checkAll();
        end
        // Reset in mid-run restores every default
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        resetModel();
        checkAll();
        finish_test();
    end
endmodule
